// File: adc_out_pkg.sv
// Constants for the converter digital output stage
package adc_out_pkg;
   // Register indices; byte address is index times four
   localparam logic [7:0] IDX_RATE = 8'h02;
   localparam logic [7:0] IDX_CFG = 8'h07;
   localparam logic [7:0] IDX_DLL_PHASE = 8'h52;
   localparam logic [7:0] IDX_OUT_CTRL = 8'h62;
   localparam logic [7:0] IDX_LVDS_CTRL = 8'h63;
   localparam logic [7:0] IDX_PHASE_EN = 8'h64;
   localparam logic [7:0] IDX_PLL_DLY = 8'h6D;
   localparam logic [7:0] IDX_USER_0 = 8'h74;
   localparam logic [7:0] IDX_USER_1 = 8'h75;
   localparam logic [7:0] IDX_USER_2 = 8'h76;
   localparam logic [7:0] IDX_USER_3 = 8'h77;
   localparam logic [7:0] IDX_TIMING = 8'h80;
   localparam logic [7:0] IDX_PAIR_EN = 8'h81;
   localparam logic [7:0] IDX_PIN_EN_LO = 8'h82;
   localparam logic [7:0] IDX_PIN_EN_HI = 8'h83;
   localparam logic [7:0] IDX_STATUS = 8'h84;
   // Field positions
   localparam int RAND_EN_BIT = 0;
   localparam int TERM_EN_BIT = 0;
   localparam int PHASE_EN_BIT = 0;
   localparam int MODE_LSB = 0;
   localparam int PAT_LSB = 2;
   localparam int RES14_BIT = 5;
   localparam int PLL_SRC_BIT = 0;
   localparam int DECIM_BIT = 1;
   localparam int DECIM_PH_LSB = 2;
   // Output modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_CMOS = 2'h1;
   // Test patterns
   localparam logic [2:0] PAT_NONE = 3'h0;
   localparam logic [2:0] PAT_ZEROS = 3'h1;
   localparam logic [2:0] PAT_ONES = 3'h2;
   localparam logic [2:0] PAT_TOGGLE = 3'h3;
   localparam logic [2:0] PAT_USER_ALT = 3'h4;
   localparam logic [2:0] PAT_PRBS = 3'h7;
   localparam logic [15:0] ALT_WORD_A = 16'hAAAA;
   localparam logic [15:0] ALT_WORD_B = 16'h5555;
   localparam logic [15:0] PRBS_SEED = 16'hFFFF;
   localparam logic [15:0] RAND_MASK = 16'hFFFE;
   localparam logic [15:0] RES14_MASK = 16'h3FFF;
   // Reset values
   localparam logic [7:0] RST_OUT_CTRL = 8'h01;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ALL_ON = 8'hFF;
   localparam logic [31:0] RD_ZERO = 32'h0;
endpackage

// File: adc_out_stage.sv
// Converter digital output stage with APB register slave
`timescale 1ns/1ns
// Overview of operation
// RL1: Internal LVDS termination is switched on only by its enable bit.
// RL2: Host must lower output data rate when decimating; rate register stored.
// RL3: CMOS mode: data changes only with output clock rising edge.
// RL4: DDR LVDS mode: data changes on both output clock edges.
// RL5: DLL or decimation phase delay applies only when enable bit set.
// RL6: DLL source without decimation uses DLL three-bit phase field.
// RL7: With decimation the decimation three-bit phase field is used.
// RL8: PLL source delays output clock by PLL three-bit delay field.
// RL9: Randomizer XORs every data bit above bit 0 with bit 0.
// RL10: Clock, flags, marker, extra bits and bit 0 bypass the randomizer.
// RL11: Randomizing happens only while its enable bit is set.
// RL12: Output mode 00 disables every output including clock and flags.
// RL13: Selected test pattern fully replaces converter samples.
// RL14: Four writable registers hold the user-defined pattern.
// RL15: Pattern 111 outputs 16-bit LFSR, 1 + x^4 + x^13 + x^15 + x^16.
// RL16: 16-bit mode: LFSR on data, bits 15,14,1,0 to flag lines.
// RL17: 14-bit mode: LFSR 15:2 on data 13:0, bits 15,14 to flags.
// RL18: CMOS mode drives pattern on every pin regardless of pin enable.
// RL19: LVDS mode drives pattern only on enabled pairs.
// RL20: DDR shared pair: flag on falling clock edge, marker on rising.
// RL21: LFSR reloads a nonzero seed whenever the pattern is selected.
module adc_out_stage
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [9:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic sample_clk_i,
   input wire logic [15:0] sample_data_i,
   input wire logic sample_ovr_i,
   input wire logic sample_wck_i,
   input wire logic [1:0] sample_extra_i,
   output logic [15:0] parallel_data_out_o,
   output logic [15:0] parallel_data_oe_o,
   output logic overrange_flag_o,
   output logic overrange_flag_oe_o,
   output logic word_marker_o,
   output logic word_marker_oe_o,
   output logic extra_low_bit_a_o,
   output logic extra_low_bit_b_o,
   output logic extra_low_bits_oe_o,
   output logic output_clock_o,
   output logic output_clock_oe_o,
   output logic lvds_mode_o,
   output logic lvds_termination_o
);
   import adc_out_pkg::*;

   logic [7:0] rate_reg, rate_next, cfg_reg, cfg_next;
   logic [7:0] dll_ph_reg, dll_ph_next, out_ctrl_reg, out_ctrl_next;
   logic [7:0] lvds_reg, lvds_next, ph_en_reg, ph_en_next;
   logic [7:0] pll_dly_reg, pll_dly_next, timing_reg, timing_next;
   logic [7:0] pair_en_reg, pair_en_next, pin_lo_reg, pin_lo_next;
   logic [7:0] pin_hi_reg, pin_hi_next;
   logic [7:0] user_reg [0:3];
   logic [7:0] user_next [0:3];
   logic pready_reg, pready_next, slverr_reg, slverr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] idx;
   logic wr_en;
   logic hit;
   logic [7:0] rd_byte;
   logic [7:0] status;

   logic [1:0] mode;
   logic [2:0] pat;
   logic res14, lvds, pat_on, out_on;
   logic [2:0] dly_sel;

   assign idx = paddr_i[9:2];
   assign mode = out_ctrl_reg[MODE_LSB +: 2];
   assign pat = out_ctrl_reg[PAT_LSB +: 3];
   assign res14 = out_ctrl_reg[RES14_BIT];
   assign out_on = (mode != MODE_OFF);
   assign lvds = out_on && (mode != MODE_CMOS);
   assign pat_on = (pat != PAT_NONE);
   assign status = {3'h0, lvds, pat_on, dly_sel};
   assign wr_en = psel_i && penable_i && pwrite_i && pready_reg;

   // Register decode and APB answer
   always_comb
   begin
      rate_next = rate_reg;
      cfg_next = cfg_reg;
      dll_ph_next = dll_ph_reg;
      out_ctrl_next = out_ctrl_reg;
      lvds_next = lvds_reg;
      ph_en_next = ph_en_reg;
      pll_dly_next = pll_dly_reg;
      timing_next = timing_reg;
      pair_en_next = pair_en_reg;
      pin_lo_next = pin_lo_reg;
      pin_hi_next = pin_hi_reg;
      for (int k = 0; k < 4; k++)
      begin
         user_next[k] = user_reg[k];
      end
      hit = 1'b1;
      rd_byte = RST_ZERO;
      case (idx)
         IDX_RATE: rd_byte = rate_reg;
         IDX_CFG: rd_byte = cfg_reg;
         IDX_DLL_PHASE: rd_byte = dll_ph_reg;
         IDX_OUT_CTRL: rd_byte = out_ctrl_reg;
         IDX_LVDS_CTRL: rd_byte = lvds_reg;
         IDX_PHASE_EN: rd_byte = ph_en_reg;
         IDX_PLL_DLY: rd_byte = pll_dly_reg;
         IDX_USER_0: rd_byte = user_reg[0];
         IDX_USER_1: rd_byte = user_reg[1];
         IDX_USER_2: rd_byte = user_reg[2];
         IDX_USER_3: rd_byte = user_reg[3];
         IDX_TIMING: rd_byte = timing_reg;
         IDX_PAIR_EN: rd_byte = pair_en_reg;
         IDX_PIN_EN_LO: rd_byte = pin_lo_reg;
         IDX_PIN_EN_HI: rd_byte = pin_hi_reg;
         IDX_STATUS: rd_byte = status;
         default: hit = 1'b0;
      endcase
      if (wr_en)
      begin
         case (idx)
            // Host-set output rate
            IDX_RATE: rate_next = pwdata_i[7:0];
            IDX_CFG: cfg_next = pwdata_i[7:0];
            IDX_DLL_PHASE: dll_ph_next = pwdata_i[7:0];
            IDX_OUT_CTRL: out_ctrl_next = pwdata_i[7:0];
            IDX_LVDS_CTRL: lvds_next = pwdata_i[7:0];
            IDX_PHASE_EN: ph_en_next = pwdata_i[7:0];
            IDX_PLL_DLY: pll_dly_next = pwdata_i[7:0];
            // RL14: user pattern bytes
            IDX_USER_0: user_next[0] = pwdata_i[7:0];
            IDX_USER_1: user_next[1] = pwdata_i[7:0];
            IDX_USER_2: user_next[2] = pwdata_i[7:0];
            IDX_USER_3: user_next[3] = pwdata_i[7:0];
            IDX_TIMING: timing_next = pwdata_i[7:0];
            IDX_PAIR_EN: pair_en_next = pwdata_i[7:0];
            IDX_PIN_EN_LO: pin_lo_next = pwdata_i[7:0];
            IDX_PIN_EN_HI: pin_hi_next = pwdata_i[7:0];
            default: hit = hit;
         endcase
      end
      // Ready in first access cycle only
      pready_next = psel_i && !penable_i;
      slverr_next = psel_i && !penable_i && !hit;
      rdata_next = rdata_reg;
      if (psel_i && !penable_i)
      begin
         rdata_next = (hit && !pwrite_i) ? {24'h0, rd_byte} : RD_ZERO;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rate_reg <= RST_ZERO;
         cfg_reg <= RST_ZERO;
         dll_ph_reg <= RST_ZERO;
         out_ctrl_reg <= RST_OUT_CTRL;
         lvds_reg <= RST_ZERO;
         ph_en_reg <= RST_ZERO;
         pll_dly_reg <= RST_ZERO;
         timing_reg <= RST_ZERO;
         pair_en_reg <= RST_ALL_ON;
         pin_lo_reg <= RST_ALL_ON;
         pin_hi_reg <= RST_ALL_ON;
         for (int k = 0; k < 4; k++)
         begin
            user_reg[k] <= RST_ZERO;
         end
         pready_reg <= 1'b0;
         slverr_reg <= 1'b0;
         rdata_reg <= RD_ZERO;
      end
      else
      begin
         rate_reg <= rate_next;
         cfg_reg <= cfg_next;
         dll_ph_reg <= dll_ph_next;
         out_ctrl_reg <= out_ctrl_next;
         lvds_reg <= lvds_next;
         ph_en_reg <= ph_en_next;
         pll_dly_reg <= pll_dly_next;
         timing_reg <= timing_next;
         pair_en_reg <= pair_en_next;
         pin_lo_reg <= pin_lo_next;
         pin_hi_reg <= pin_hi_next;
         for (int k = 0; k < 4; k++)
         begin
            user_reg[k] <= user_next[k];
         end
         pready_reg <= pready_next;
         slverr_reg <= slverr_next;
         rdata_reg <= rdata_next;
      end
   end

   assign pready_o = pready_reg;
   assign pslverr_o = slverr_reg;
   assign prdata_o = rdata_reg;

   // Pin sync; stages two and three feed logic
   logic sclk1_reg, sclk2_reg, sclk3_reg;
   logic rise;
   logic [15:0] lfsr_reg, lfsr_next, word_reg, word_next;
   logic alt_reg, alt_next;
   logic ovr_reg, ovr_next, wck_reg, wck_next;
   logic [1:0] extra_reg, extra_next;
   logic [15:0] p16, full, mapped;
   logic p_ovr, p_wck;
   logic [1:0] p_extra;
   logic fb;

   assign rise = sclk2_reg && !sclk3_reg;
   // RL15: taps 16, 15, 13 and 4
   assign fb = lfsr_reg[15] ^ lfsr_reg[14] ^ lfsr_reg[12] ^ lfsr_reg[3];

   always_comb
   begin
      case (pat)
         PAT_ZEROS: p16 = 16'h0000;
         PAT_ONES: p16 = 16'hFFFF;
         PAT_TOGGLE: p16 = alt_reg ? ALT_WORD_B : ALT_WORD_A;
         PAT_USER_ALT: p16 = alt_reg ? {user_reg[3], user_reg[2]}
                                     : {user_reg[1], user_reg[0]};
         PAT_PRBS: p16 = lfsr_reg;
         default: p16 = {user_reg[1], user_reg[0]};
      endcase
      // RL13: pattern replaces samples
      if (pat_on)
      begin
         full = p16;
         p_ovr = p16[15];
         p_wck = p16[14];
         // RL16: low LFSR bits to extra outputs
         p_extra = p16[1:0];
      end
      else
      begin
         full = sample_data_i;
         p_ovr = sample_ovr_i;
         p_wck = sample_wck_i;
         p_extra = sample_extra_i;
      end
      // RL17: 14-bit keeps top fourteen bits
      mapped = res14 ? {2'h0, full[15:2]} : full;
      // RL9: XOR with bit 0
      // RL11: only when enabled
      if (cfg_reg[RAND_EN_BIT])
      begin
         mapped = mapped ^ ({16{mapped[0]}} & RAND_MASK);
      end
      if (res14)
      begin
         mapped = mapped & RES14_MASK;
         p_extra = 2'h0;
      end
      word_next = word_reg;
      ovr_next = ovr_reg;
      wck_next = wck_reg;
      extra_next = extra_reg;
      alt_next = alt_reg;
      lfsr_next = lfsr_reg;
      // RL21: seed held until selected
      if (pat != PAT_PRBS)
      begin
         lfsr_next = PRBS_SEED;
      end
      if (rise)
      begin
         // RL10: flags bypass randomizer
         word_next = mapped;
         ovr_next = p_ovr;
         wck_next = p_wck;
         extra_next = p_extra;
         alt_next = !alt_reg;
         if (pat == PAT_PRBS)
         begin
            lfsr_next = {lfsr_reg[14:0], fb};
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sclk1_reg <= 1'b0;
         sclk2_reg <= 1'b0;
         sclk3_reg <= 1'b0;
         word_reg <= 16'h0000;
         ovr_reg <= 1'b0;
         wck_reg <= 1'b0;
         extra_reg <= 2'h0;
         alt_reg <= 1'b0;
         lfsr_reg <= PRBS_SEED;
      end
      else
      begin
         sclk1_reg <= sample_clk_i;
         sclk2_reg <= sclk1_reg;
         sclk3_reg <= sclk2_reg;
         word_reg <= word_next;
         ovr_reg <= ovr_next;
         wck_reg <= wck_next;
         extra_reg <= extra_next;
         alt_reg <= alt_next;
         lfsr_reg <= lfsr_next;
      end
   end

   // Phase delay: one tap per clock
   logic [6:0] dly_reg, dly_next;
   logic [7:0] taps;
   logic [7:0] ddr_lanes;
   logic [15:0] data_next, oe_next;
   logic oclk_next, ovr_o_next, wck_o_next;
   logic [1:0] extra_o_next;
   logic [3:0] ctl_oe_next;
   logic [3:0] ctl_oe_reg;

   assign taps = {dly_reg, sclk3_reg};

   always_comb
   begin
      // RL8: PLL delay field
      if (timing_reg[PLL_SRC_BIT])
      begin
         dly_sel = pll_dly_reg[2:0];
      end
      // RL5: phase enable gate
      else if (!ph_en_reg[PHASE_EN_BIT])
      begin
         dly_sel = 3'h0;
      end
      // RL7: decimation phase field
      else if (timing_reg[DECIM_BIT])
      begin
         dly_sel = timing_reg[DECIM_PH_LSB +: 3];
      end
      // RL6: DLL phase field
      else
      begin
         dly_sel = dll_ph_reg[2:0];
      end
   end

   // RL4: even bit while clock high, odd while low
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_lane
         assign ddr_lanes[gi] = sclk3_reg ? word_reg[2 * gi]
                                          : word_reg[2 * gi + 1];
      end
   endgenerate

   always_comb
   begin
      dly_next = {dly_reg[5:0], sclk3_reg};
      oclk_next = taps[dly_sel];
      if (lvds)
      begin
         data_next = {8'h00, ddr_lanes};
         // RL19: enabled pairs only
         oe_next = {8'h00, pair_en_reg};
         // RL20: marker while clock high, flag while low
         ovr_o_next = sclk3_reg ? wck_reg : ovr_reg;
         wck_o_next = 1'b0;
         extra_o_next = 2'h0;
         ctl_oe_next = 4'b1001;
      end
      else
      begin
         // RL3: word moves on rising edge only
         data_next = word_reg;
         // RL18: pattern drives every CMOS pin
         oe_next = pat_on ? 16'hFFFF : {pin_hi_reg, pin_lo_reg};
         ovr_o_next = ovr_reg;
         wck_o_next = wck_reg;
         extra_o_next = extra_reg;
         ctl_oe_next = 4'b1111;
      end
      // RL12: mode 00 silences everything
      if (!out_on)
      begin
         data_next = 16'h0000;
         oe_next = 16'h0000;
         oclk_next = 1'b0;
         ovr_o_next = 1'b0;
         wck_o_next = 1'b0;
         extra_o_next = 2'h0;
         ctl_oe_next = 4'h0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         dly_reg <= 7'h00;
         parallel_data_out_o <= 16'h0000;
         parallel_data_oe_o <= 16'h0000;
         output_clock_o <= 1'b0;
         overrange_flag_o <= 1'b0;
         word_marker_o <= 1'b0;
         extra_low_bit_a_o <= 1'b0;
         extra_low_bit_b_o <= 1'b0;
         ctl_oe_reg <= 4'h0;
         lvds_mode_o <= 1'b0;
         lvds_termination_o <= 1'b0;
      end
      else
      begin
         dly_reg <= dly_next;
         parallel_data_out_o <= data_next;
         parallel_data_oe_o <= oe_next;
         output_clock_o <= oclk_next;
         overrange_flag_o <= ovr_o_next;
         word_marker_o <= wck_o_next;
         extra_low_bit_a_o <= extra_o_next[1];
         extra_low_bit_b_o <= extra_o_next[0];
         ctl_oe_reg <= ctl_oe_next;
         lvds_mode_o <= lvds;
         // RL1: termination follows its bit
         lvds_termination_o <= lvds_reg[TERM_EN_BIT];
      end
   end

   assign output_clock_oe_o = ctl_oe_reg[3];
   assign word_marker_oe_o = ctl_oe_reg[2];
   assign extra_low_bits_oe_o = ctl_oe_reg[1];
   assign overrange_flag_oe_o = ctl_oe_reg[0];
endmodule

// File: adc_out_stage_asserts.sv
// Port assertions for the output stage
`timescale 1ns/1ns
module adc_out_stage_asserts
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [15:0] parallel_data_out_o,
   input wire logic [15:0] parallel_data_oe_o,
   input wire logic overrange_flag_oe_o,
   input wire logic word_marker_oe_o,
   input wire logic output_clock_o,
   input wire logic output_clock_oe_o,
   input wire logic lvds_mode_o,
   input wire logic lvds_termination_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic wr_acc;
   assign wr_acc = psel_i && penable_i && pwrite_i && pready_o;
   sequence s_setup;
      psel_i && !penable_i;
   endsequence
   sequence s_off;
      !output_clock_oe_o [*2];
   endsequence
   // Config writes may legally reshape the word mid-period
   sequence s_cmos_quiet;
      output_clock_oe_o && !lvds_mode_o && $stable(lvds_mode_o)
         && $stable(output_clock_oe_o) && !$past(wr_acc) && !$past(wr_acc, 2);
   endsequence
   sequence s_wrote;
      $past(wr_acc) || $past(wr_acc, 2) || $past(wr_acc, 3);
   endsequence
   property p_ready_after_setup;
      s_setup |=> pready_o;
   endproperty
   property p_ready_in_access;
      pready_o |-> psel_i && penable_i;
   endproperty
   property p_ready_one;
      pready_o |=> !pready_o;
   endproperty
   property p_err_with_ready;
      pslverr_o |-> pready_o;
   endproperty
   property p_err_reads_zero;
      pslverr_o && !pwrite_i |-> prdata_o == 32'h0;
   endproperty
   property p_term_by_write;
      $changed(lvds_termination_o) |-> s_wrote;
   endproperty
   property p_mode_by_write;
      $changed(lvds_mode_o) |-> s_wrote;
   endproperty
   property p_cmos_edge;
      s_cmos_quiet ##0 $changed(parallel_data_out_o) |-> !$past(output_clock_o);
   endproperty
   property p_off_quiet;
      s_off |-> parallel_data_oe_o == 16'h0000 && parallel_data_out_o == 16'h0000
         && !overrange_flag_oe_o && !word_marker_oe_o && !output_clock_o;
   endproperty
   a_ready_after_setup: assert property (p_ready_after_setup)
      else $error("no ready after setup");
   a_ready_in_access: assert property (p_ready_in_access)
      else $error("ready outside access");
   a_ready_one: assert property (p_ready_one)
      else $error("ready over one cycle");
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("error without ready");
   a_err_reads_zero: assert property (p_err_reads_zero)
      else $error("refused read not zero");
   a_term_by_write: assert property (p_term_by_write)
      else $error("stray termination change");
   a_mode_by_write: assert property (p_mode_by_write)
      else $error("stray lane mode change");
   a_cmos_edge: assert property (p_cmos_edge)
      else $error("data moved with clock high");
   a_off_quiet: assert property (p_off_quiet)
      else $error("outputs active when off");
endmodule

// File: adc_out_stage_test.sv
// Self-checking bench for the output stage
`timescale 1ns/1ns
module adc_out_stage_test;
   import adc_out_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [9:0] paddr_i = 10'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic sample_clk_i = 1'b0;
   logic [15:0] sample_data_i = 16'h0000;
   logic sample_ovr_i = 1'b0;
   logic sample_wck_i = 1'b0;
   logic [1:0] sample_extra_i = 2'h0;
   logic rand_en = 1'b0;
   logic pready_o, pslverr_o, overrange_flag_o, overrange_flag_oe_o;
   logic word_marker_o, word_marker_oe_o, extra_low_bit_a_o, extra_low_bit_b_o;
   logic extra_low_bits_oe_o, output_clock_o, output_clock_oe_o;
   logic lvds_mode_o, lvds_termination_o, host_flag, e;
   logic [31:0] prdata_o, host_count;
   logic [15:0] parallel_data_out_o, parallel_data_oe_o, host_word, host_plain, w;
   logic [7:0] q;
   logic [2:0] sdiv = 3'h0;
   int fails = 0;
   int checked = 0;
   localparam logic [15:0] DCASE [5] = '{16'h0000, 16'h0015, 16'h0E13,
      16'h0E00, 16'h0106};
   localparam logic [7:0] UV [4] = '{8'h34, 8'h12, 8'hCD, 8'hAB};
   adc_out_stage adc_out_stage_inst
   (
      .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .pready_o, .prdata_o, .pslverr_o, .sample_clk_i, .sample_data_i,
      .sample_ovr_i, .sample_wck_i, .sample_extra_i, .parallel_data_out_o,
      .parallel_data_oe_o, .overrange_flag_o, .overrange_flag_oe_o,
      .word_marker_o, .word_marker_oe_o, .extra_low_bit_a_o, .extra_low_bit_b_o,
      .extra_low_bits_oe_o, .output_clock_o, .output_clock_oe_o, .lvds_mode_o,
      .lvds_termination_o
   );
   capture_host_model capture_host_model_inst
   (
      .clk_i, .rst_i, .out_clk_i(output_clock_o), .lvds_i(lvds_mode_o),
      .rand_en_i(rand_en), .pins_i(parallel_data_out_o),
      .flag_i(overrange_flag_o), .word_o(host_word), .plain_o(host_plain),
      .flag_o(host_flag), .count_o(host_count)
   );
   always #5 clk_i = ~clk_i;
   // 160 ns converter strobe on clock grid
   always @(posedge clk_i)
   begin
      sdiv <= sdiv + 3'h1;
      if (sdiv == 3'h7)
         sample_clk_i <= ~sample_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, x, s);
      end
   endtask
   task apb(input logic wn, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= wn;
      paddr_i <= {a, 2'h0};
      pwdata_i <= {24'h0, d};
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      chk("ready", n < 20, 1);
      q = prdata_o[7:0];
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task cap(input int n);
      logic [31:0] c;
      int t;
      repeat (n)
      begin
         c = host_count;
         t = 0;
         while (host_count === c && t < 100)
         begin
            @(posedge clk_i);
            t++;
         end
         chk("capture", t < 100, 1);
      end
   endtask
   task t_regs;
      apb(0, IDX_OUT_CTRL, 0);
      chk("out_ctrl", q, RST_OUT_CTRL);
      apb(0, IDX_PAIR_EN, 0);
      chk("pair_en", q, RST_ALL_ON);
      apb(0, IDX_CFG, 0);
      chk("cfg", q, RST_ZERO);
      for (int i = 0; i < 4; i++)
         apb(1, IDX_USER_0 + 8'(i), UV[i]);
      for (int i = 0; i < 4; i++)
      begin
         apb(0, IDX_USER_0 + 8'(i), 0);
         chk("user", q, UV[i]);
      end
      apb(0, 8'h10, 0);
      chk("unmapped", {e, q}, 9'h100);
      apb(1, IDX_RATE, 8'h01);
      for (int i = 0; i < 2; i++)
      begin
         apb(1, IDX_LVDS_CTRL, 8'(1 - i));
         repeat (3) @(posedge clk_i);
         chk("term", lvds_termination_o, 1 - i);
      end
      $display("test regs done");
   endtask
   task t_delay;
      apb(1, IDX_DLL_PHASE, 8'h05);
      apb(1, IDX_PLL_DLY, 8'h06);
      for (int i = 0; i < 5; i++)
      begin
         apb(1, IDX_TIMING, DCASE[i][15:8]);
         apb(1, IDX_PHASE_EN, {4'h0, DCASE[i][7:4]});
         apb(0, IDX_STATUS, 0);
         chk("delay", q[2:0], DCASE[i][2:0]);
      end
      apb(1, IDX_TIMING, 8'h00);
      apb(1, IDX_PHASE_EN, 8'h00);
      $display("test delay done");
   endtask
   task t_cmos;
      sample_data_i <= 16'h8C35;
      sample_ovr_i <= 1'b1;
      sample_extra_i <= 2'h3;
      cap(2);
      chk("plain", host_word, 16'h8C35);
      apb(1, IDX_CFG, 8'h01);
      rand_en <= 1'b1;
      cap(2);
      chk("rand", host_word, 16'h73CB);
      chk("undo", host_plain, 16'h8C35);
      chk("bypass", {host_flag, extra_low_bit_a_o}, 2'h3);
      apb(1, IDX_CFG, 8'h00);
      rand_en <= 1'b0;
      $display("test cmos done");
   endtask
   task t_pat;
      // Low pins off, pattern must still show
      apb(1, IDX_PIN_EN_LO, 8'h00);
      for (int p = 1; p < 7; p++)
      begin
         apb(1, IDX_OUT_CTRL, {3'h0, 3'(p), MODE_CMOS});
         cap(2);
         w = host_word;
         cap(1);
         if (p == 3)
            chk("alt", w ^ host_word, ALT_WORD_A ^ ALT_WORD_B);
         else if (p == 4)
            chk("user_alt", w ^ host_word, 16'h1234 ^ 16'hABCD);
         else
            chk("pattern", host_word, p == 1 ? 0 : p == 2 ? 16'hFFFF : 16'h1234);
      end
      apb(1, IDX_PIN_EN_LO, RST_ALL_ON);
      $display("test patterns done");
   endtask
   task t_prbs;
      apb(1, IDX_OUT_CTRL, 8'h1D);
      cap(1);
      w = host_word;
      cap(1);
      chk("seed", w === 16'hFFFF || host_word === 16'hFFFF, 1);
      repeat (4)
      begin
         w = host_word;
         cap(1);
         chk("lfsr", host_word, {w[14:0], w[15] ^ w[14] ^ w[12] ^ w[3]});
         chk("copies", {overrange_flag_o, word_marker_o, extra_low_bit_a_o,
            extra_low_bit_b_o}, {host_word[15:14], host_word[1:0]});
      end
      apb(1, IDX_OUT_CTRL, 8'h3D);
      cap(2);
      w = host_word;
      cap(1);
      chk("lfsr14", host_word[13:1], w[12:0]);
      chk("top14", {host_word[15:14], extra_low_bit_a_o, extra_low_bit_b_o}, 0);
      chk("flag14", overrange_flag_o, host_word[13]);
      $display("test prbs done");
   endtask
   task t_lvds;
      apb(1, IDX_OUT_CTRL, 8'h02);
      cap(3);
      chk("lvds", {lvds_mode_o, host_word}, 17'h18C35);
      chk("ddr_flag", host_flag, 1);
      apb(1, IDX_PAIR_EN, 8'hFE);
      repeat (3) @(posedge clk_i);
      chk("pair_oe", parallel_data_oe_o[1:0], 2'h2);
      apb(1, IDX_PAIR_EN, RST_ALL_ON);
      $display("test lvds done");
   endtask
   task t_off;
      apb(1, IDX_OUT_CTRL, {6'h00, MODE_OFF});
      repeat (3) @(posedge clk_i);
      repeat (20)
      begin
         @(posedge clk_i);
         chk("off_data", {parallel_data_out_o, parallel_data_oe_o}, 0);
         chk("off_ctl", {overrange_flag_o, overrange_flag_oe_o, word_marker_o,
            word_marker_oe_o, extra_low_bit_a_o, extra_low_bit_b_o,
            extra_low_bits_oe_o, output_clock_o, output_clock_oe_o}, 0);
      end
      $display("test off done");
   endtask
   task summarize;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs;
      t_delay;
      t_cmos;
      t_pat;
      t_prbs;
      t_lvds;
      t_off;
      summarize;
   end
   initial
   begin
      #200000;
      fails++;
      summarize;
   end
endmodule
bind adc_out_stage adc_out_stage_asserts adc_out_stage_asserts_inst
(
   .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .pready_o, .prdata_o,
   .pslverr_o, .parallel_data_out_o, .parallel_data_oe_o, .overrange_flag_oe_o,
   .word_marker_oe_o, .output_clock_o, .output_clock_oe_o, .lvds_mode_o,
   .lvds_termination_o
);

// File: capture_host_model.sv
// Host model capturing output words
`timescale 1ns/1ns
module capture_host_model
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic out_clk_i,
   input wire logic lvds_i,
   input wire logic rand_en_i,
   input wire logic [15:0] pins_i,
   input wire logic flag_i,
   output logic [15:0] word_o,
   output logic [15:0] plain_o,
   output logic flag_o,
   output logic [31:0] count_o
);
   logic clk_q;
   logic flag_q;
   logic [15:0] pins_q;
   logic [7:0] even_q;
   assign plain_o = word_o ^ ({16{rand_en_i & word_o[0]}} & 16'hFFFE);
   // Pins taken a cycle late: edge seen, data still old
   always_ff @(posedge clk_i)
   begin
      clk_q <= out_clk_i;
      pins_q <= pins_i;
      flag_q <= flag_i;
      if (rst_i)
      begin
         count_o <= 32'h0;
      end
      else if (clk_q && !out_clk_i && !lvds_i)
      begin
         word_o <= pins_q;
         flag_o <= flag_q;
         count_o <= count_o + 32'h1;
      end
      else if (clk_q && !out_clk_i)
      begin
         even_q <= pins_q[7:0];
      end
      else if (!clk_q && out_clk_i && lvds_i)
      begin
         for (int i = 0; i < 8; i++)
         begin
            word_o[2*i] <= even_q[i];
            word_o[2*i+1] <= pins_q[i];
         end
         flag_o <= flag_q;
         count_o <= count_o + 32'h1;
      end
   end
endmodule
